// file: logic/dlec_map.vh
// Purpose: Constants for the two-line erase and register command block
// Assumes: Included once per design file by bare name
// Notes:   Opcodes, bus offsets, bit positions, reset values, timing
`ifndef DLEC_MAP_VH
`define DLEC_MAP_VH

// Command opcodes
`define DLEC_OP_WRITE_UNLOCK_CMD     8'h06
`define DLEC_OP_WRDI     8'h04
`define DLEC_OP_SECT     8'hd8
`define DLEC_OP_BULK     8'hc7
`define DLEC_OP_PAUSE    8'h75
`define DLEC_OP_RESUME   8'h7a
`define DLEC_OP_SR_RD    8'h05
`define DLEC_OP_SR_WR    8'h01
`define DLEC_OP_LK_RD    8'he8
`define DLEC_OP_LK_WR    8'he5
`define DLEC_OP_FL_RD    8'h70
`define DLEC_OP_FL_CLR   8'h50
`define DLEC_OP_NV_RD    8'hb5
`define DLEC_OP_NV_WR    8'hb1
`define DLEC_OP_VC_RD    8'h85
`define DLEC_OP_VC_WR    8'h81
`define DLEC_OP_EC_RD    8'h65
`define DLEC_OP_EC_WR    8'h61

// Frame lengths in rising clock edges (two bits per edge)
`define DLEC_EDG_OP      6'd4
`define DLEC_EDG_A3      6'd12
`define DLEC_EDG_A4      6'd16
`define DLEC_EDG_BYTE    6'd4

// Bus register word offsets (address bits 7:2)
`define DLEC_OFS_CTRL    6'h00
`define DLEC_OFS_STAT    6'h01
`define DLEC_OFS_NVCFG   6'h02
`define DLEC_OFS_MADDR   6'h03
`define DLEC_OFS_MDATA   6'h04

// Control register fields
`define DLEC_CTRL_4B     0

// Reset values
`define DLEC_RST_SR      6'h00
`define DLEC_RST_NV      16'hffff
`define DLEC_RST_VC      8'hfb
`define DLEC_RST_EC      8'hdf
`define DLEC_RST_PINS    4'b0100

// Timing: persistent config write time and its cycle count at 50 MHz
`define DLEC_CLK_NS      20
`define DLEC_NV_WR_NS    2000
`define DLEC_NV_WR_CYC   ((`DLEC_NV_WR_NS + `DLEC_CLK_NS - 1) / `DLEC_CLK_NS)

`endif

// file: logic/dlec_top.v
// Purpose: Two-line serial command interpreter: erase, suspend, register access
// Assumes: Host drives chip select and mode 0 serial clock; data two bits per edge
// Notes:   Array is modelled small; software sees state over AHB-Lite
`include "dlec_map.vh"

module dlec_top #(
  parameter ADDR_W    = 12,
  parameter SECT_W    = 8,
  parameter NV_WR_CYC = `DLEC_NV_WR_CYC
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // Serial link pins
  input  wire        link_sclk,
  input  wire        link_cs_n,
  input  wire        data_line_0_in,
  input  wire        data_line_1_in,
  output wire        data_line_0_out,
  output wire        data_line_1_out,
  output wire        data_line_0_oe,
  output wire        data_line_1_oe,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata
);

  localparam NSECT = 1 << (ADDR_W - SECT_W);
  localparam LK_W  = ADDR_W - SECT_W;
  // Idle level of each synced pin, one bit per pin
  localparam [3:0] PIN_RST = `DLEC_RST_PINS;

  // Engine kinds
  localparam K_IDLE = 2'd0;
  localparam K_SECT = 2'd1;
  localparam K_BULK = 2'd2;
  localparam K_NV   = 2'd3;

  // Read-back selections
  localparam T_SR = 3'd0;
  localparam T_FL = 3'd1;
  localparam T_NV = 3'd2;
  localparam T_VC = 3'd3;
  localparam T_EC = 3'd4;
  localparam T_LK = 3'd5;

  wire [3:0] pin_raw;
  wire [3:0] pin_st;
  reg        sclk_p_q;
  reg        cs_p_q;

  assign pin_raw = {link_sclk, link_cs_n, data_line_1_in, data_line_0_in};

  // Three-stage input sync, change taken when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      reg [2:0] s_q;
      reg       st_q;
      always @(posedge core_clk) begin
        if (!rst_n) begin
          s_q  <= {3{PIN_RST[gi]}};
          st_q <= PIN_RST[gi];
        end else begin
          s_q <= {s_q[1:0], pin_raw[gi]};
          if (s_q[1] == s_q[2])
            st_q <= s_q[2];
        end
      end
      assign pin_st[gi] = st_q;
    end
  endgenerate

  wire sclk_s = pin_st[3];
  wire cs_s   = pin_st[2];
  wire rise   = sclk_s & ~sclk_p_q;
  wire fall   = ~sclk_s & sclk_p_q;
  wire cs_up  = cs_s & ~cs_p_q;
  wire cs_dn  = ~cs_s & cs_p_q;

  // Link state
  reg [5:0]  cnt_q;
  reg [31:0] sh_q;
  reg [7:0]  op_q;
  reg [LK_W-1:0] la_q;
  reg        tx_q;
  reg [2:0]  tsel_q;
  reg [2:0]  fcnt_q;
  reg        d0_q;
  reg        d1_q;
  reg        oe_q;
  // Device registers
  reg        wel_q;
  reg [7:2]  sr_q;
  reg        e_ers_q;
  reg        e_prg_q;
  reg        e_vpp_q;
  reg        e_prt_q;
  reg [15:0] nv_q;
  reg [15:0] nv_new_q;
  reg [7:0]  vc_q;
  reg [7:0]  ec_q;
  reg [1:0]  lock_q [0:NSECT-1];
  // Erase and write engine
  reg [1:0]  kind_q;
  reg        susp_q;
  reg [ADDR_W-1:0] ptr_q;
  reg [15:0] tmr_q;
  // Bus side
  reg        ctl4_q;
  reg [ADDR_W-1:0] mad_q;
  reg [7:0]  mrd_q;
  reg        ap_q;
  reg        aw_q;
  reg [5:0]  aa_q;
  reg        hrdy_q;
  reg        hrsp_q;
  reg [31:0] hrd_q;
  reg [7:0]  mem [0:(1<<ADDR_W)-1];

  wire [31:0] sh_nx  = {sh_q[29:0], pin_st[1], pin_st[0]};
  wire [5:0]  alen   = ctl4_q ? `DLEC_EDG_A4 : `DLEC_EDG_A3;
  wire [5:0]  a_end  = `DLEC_EDG_OP + alen;
  wire        busy   = (kind_q != K_IDLE);
  wire        wip    = busy & ~susp_q;
  wire        run    = busy & ~susp_q;
  wire        gate   = wel_q & ~busy;
  wire [7:0]  sr_rd  = {sr_q, wel_q, wip};
  wire [7:0]  fl_rd  = {~wip, susp_q, e_ers_q, e_prg_q,
                        e_vpp_q, 1'b0, e_prt_q, ctl4_q};
  wire [LK_W-1:0] se_sec = sh_q[ADDR_W-1:SECT_W];
  wire [ADDR_W-1:0] sec_base = {se_sec, {SECT_W{1'b0}}};
  wire        sec_end = &ptr_q[SECT_W-1:0];
  wire        arr_end = &ptr_q;
  wire        mem_we  = run & (kind_q != K_NV);

  // Any sector locked against writes
  reg any_lock;
  integer li;
  always @* begin
    any_lock = 1'b0;
    for (li = 0; li < NSECT; li = li + 1)
      any_lock = any_lock | lock_q[li][0];
  end

  // Read-back value, live, rotated two bits per falling edge
  reg [15:0] tx_val;
  always @* begin
    case (tsel_q)
      T_SR:    tx_val = {sr_rd, sr_rd};
      T_FL:    tx_val = {fl_rd, fl_rd};
      T_NV:    tx_val = {nv_q[7:0], nv_q[15:8]};
      T_VC:    tx_val = {vc_q, vc_q};
      T_EC:    tx_val = {ec_q, ec_q};
      T_LK:    tx_val = {6'h00, lock_q[la_q], 6'h00, lock_q[la_q]};
      default: tx_val = 16'h0000;
    endcase
  end
  wire [15:0] tx_rot = tx_val << {fcnt_q, 1'b0};

  // Edge history of synced clock and select
  always @(posedge core_clk) begin
    if (!rst_n) begin
      sclk_p_q <= 1'b0;
      cs_p_q   <= 1'b1;
    end else begin
      sclk_p_q <= sclk_s;
      cs_p_q   <= cs_s;
    end
  end

  // Frame shifter, decode, output driver
  always @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q  <= 6'd0;
      sh_q   <= 32'h0;
      op_q   <= 8'h00;
      la_q   <= {LK_W{1'b0}};
      tx_q   <= 1'b0;
      tsel_q <= T_SR;
      fcnt_q <= 3'd0;
      d0_q   <= 1'b0;
      d1_q   <= 1'b0;
      oe_q   <= 1'b0;
    end else if (cs_s) begin
      tx_q   <= 1'b0;
      oe_q   <= 1'b0;
      fcnt_q <= 3'd0;
    end else if (cs_dn) begin
      cnt_q <= 6'd0;
      sh_q  <= 32'h0;
      op_q  <= 8'h00;
    end else begin
      if (rise) begin
        sh_q <= sh_nx;
        if (cnt_q != 6'd63)
          cnt_q <= cnt_q + 6'd1;
        // Opcode complete: start replies that need no address
        if (cnt_q == `DLEC_EDG_OP - 6'd1) begin
          op_q <= sh_nx[7:0];
          tx_q <= 1'b1;
          case (sh_nx[7:0])
            `DLEC_OP_SR_RD: tsel_q <= T_SR;
            `DLEC_OP_FL_RD: tsel_q <= T_FL;
            `DLEC_OP_NV_RD: tsel_q <= T_NV;
            `DLEC_OP_VC_RD: tsel_q <= T_VC;
            `DLEC_OP_EC_RD: tsel_q <= T_EC;
            default:        tx_q   <= 1'b0;
          endcase
        end
        // Address complete for lock access
        if (cnt_q == a_end - 6'd1) begin
          la_q <= sh_nx[ADDR_W-1:SECT_W];
          if (op_q == `DLEC_OP_LK_RD) begin
            tx_q   <= 1'b1;
            tsel_q <= T_LK;
          end
        end
      end
      // Drive two bits per falling edge, high pair first
      if (fall && tx_q) begin
        d1_q   <= tx_rot[15];
        d0_q   <= tx_rot[14];
        oe_q   <= 1'b1;
        fcnt_q <= fcnt_q + 3'd1;
      end
    end
  end

  // Command execution at select release, and the erase engine
  integer ri;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      wel_q    <= 1'b0;
      sr_q     <= `DLEC_RST_SR;
      e_ers_q  <= 1'b0;
      e_prg_q  <= 1'b0;
      e_vpp_q  <= 1'b0;
      e_prt_q  <= 1'b0;
      nv_q     <= `DLEC_RST_NV;
      nv_new_q <= `DLEC_RST_NV;
      vc_q     <= `DLEC_RST_VC;
      ec_q     <= `DLEC_RST_EC;
      kind_q   <= K_IDLE;
      susp_q   <= 1'b0;
      ptr_q    <= {ADDR_W{1'b0}};
      tmr_q    <= 16'h0;
      for (ri = 0; ri < NSECT; ri = ri + 1)
        lock_q[ri] <= 2'b00;
    end else begin
      // Engine steps while not paused
      if (run) begin
        case (kind_q)
          K_SECT: begin
            ptr_q <= ptr_q + 1'b1;
            if (sec_end)
              kind_q <= K_IDLE;
          end
          K_BULK: begin
            ptr_q <= ptr_q + 1'b1;
            if (arr_end)
              kind_q <= K_IDLE;
          end
          default: begin
            tmr_q <= tmr_q - 16'd1;
            if (tmr_q == 16'd1) begin
              nv_q   <= nv_new_q;
              kind_q <= K_IDLE;
            end
          end
        endcase
      end
      // Commands end on a whole frame; wrong length is dropped
      if (cs_up) begin
        case (op_q)
          `DLEC_OP_WRITE_UNLOCK_CMD:
            if (cnt_q == `DLEC_EDG_OP)
              wel_q <= 1'b1;
          `DLEC_OP_WRDI:
            if (cnt_q == `DLEC_EDG_OP)
              wel_q <= 1'b0;
          `DLEC_OP_FL_CLR:
            if (cnt_q == `DLEC_EDG_OP) begin
              e_ers_q <= 1'b0;
              e_prg_q <= 1'b0;
              e_vpp_q <= 1'b0;
              e_prt_q <= 1'b0;
            end
          `DLEC_OP_PAUSE:
            // Sector erase only; ignored if it finishes on this very edge, else pause sticks
            if (cnt_q == `DLEC_EDG_OP && kind_q == K_SECT && !(run && sec_end))
              susp_q <= 1'b1;
          `DLEC_OP_RESUME:
            if (cnt_q == `DLEC_EDG_OP)
              susp_q <= 1'b0;
          `DLEC_OP_SECT:
            if (cnt_q == a_end && gate) begin
              wel_q <= 1'b0;
              if (lock_q[se_sec][0]) begin
                e_prt_q <= 1'b1;
                e_ers_q <= 1'b1;
              end else begin
                kind_q <= K_SECT;
                ptr_q  <= sec_base;
              end
            end
          `DLEC_OP_BULK:
            if (cnt_q == `DLEC_EDG_OP && gate) begin
              wel_q <= 1'b0;
              if (any_lock) begin
                e_prt_q <= 1'b1;
                e_ers_q <= 1'b1;
              end else begin
                kind_q <= K_BULK;
                ptr_q  <= {ADDR_W{1'b0}};
              end
            end
          `DLEC_OP_SR_WR:
            if (cnt_q == `DLEC_EDG_OP + `DLEC_EDG_BYTE && gate) begin
              wel_q <= 1'b0;
              if (!sr_q[7] || sh_q[7])
                sr_q <= sh_q[7:2];
            end
          `DLEC_OP_LK_WR:
            if (cnt_q == a_end + `DLEC_EDG_BYTE && gate) begin
              wel_q <= 1'b0;
              if (!lock_q[la_q][1])
                lock_q[la_q] <= sh_q[1:0];
            end
          `DLEC_OP_NV_WR:
            if (cnt_q == `DLEC_EDG_OP + 6'd8 && gate) begin
              wel_q    <= 1'b0;
              nv_new_q <= {sh_q[7:0], sh_q[15:8]};
              kind_q   <= K_NV;
              tmr_q    <= NV_WR_CYC[15:0];
            end
          `DLEC_OP_VC_WR:
            if (cnt_q == `DLEC_EDG_OP + `DLEC_EDG_BYTE && gate) begin
              wel_q <= 1'b0;
              vc_q  <= sh_q[7:0];
            end
          `DLEC_OP_EC_WR:
            if (cnt_q == `DLEC_EDG_OP + `DLEC_EDG_BYTE && gate) begin
              wel_q <= 1'b0;
              ec_q  <= sh_q[7:0];
            end
          default: ;
        endcase
      end
    end
  end

  // Array: erase writes, bus reads
  always @(posedge core_clk) begin
    if (mem_we)
      mem[ptr_q] <= 8'hff;
    mrd_q <= mem[mad_q];
  end

  // AHB-Lite slave, one wait state per transfer
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ap_q   <= 1'b0;
      aw_q   <= 1'b0;
      aa_q   <= 6'h00;
      hrdy_q <= 1'b1;
      hrsp_q <= 1'b0;
      hrd_q  <= 32'h0;
      ctl4_q <= 1'b0;
      mad_q  <= {ADDR_W{1'b0}};
    end else if (ap_q) begin
      ap_q   <= 1'b0;
      hrdy_q <= 1'b1;
      hrd_q  <= 32'h0;
      if (aw_q) begin
        if (aa_q == `DLEC_OFS_CTRL)
          ctl4_q <= hwdata[`DLEC_CTRL_4B];
        if (aa_q == `DLEC_OFS_MADDR)
          mad_q <= hwdata[ADDR_W-1:0];
      end else begin
        case (aa_q)
          `DLEC_OFS_CTRL:  hrd_q <= {31'h0, ctl4_q};
          `DLEC_OFS_STAT:  hrd_q <= {ec_q, vc_q, fl_rd, sr_rd};
          `DLEC_OFS_NVCFG: hrd_q <= {16'h0, nv_q};
          `DLEC_OFS_MADDR: hrd_q <= {{(32-ADDR_W){1'b0}}, mad_q};
          `DLEC_OFS_MDATA: hrd_q <= {24'h0, mrd_q};
          default:         hrd_q <= 32'h0;
        endcase
      end
    end else if (hsel && htrans[1] && hready) begin
      ap_q   <= 1'b1;
      aw_q   <= hwrite;
      aa_q   <= haddr[7:2];
      hrdy_q <= 1'b0;
    end
  end

  assign data_line_0_out = d0_q;
  assign data_line_1_out = d1_q;
  assign data_line_0_oe  = oe_q;
  assign data_line_1_oe  = oe_q;
  assign hreadyout       = hrdy_q;
  assign hresp           = hrsp_q;
  assign hrdata          = hrd_q;

endmodule // dlec_top

// file: sim/dlec_host.sv
// Purpose: Host controller model on the two-line link
// Assumes: Mode 0 clock, 160 ns period, idle low outside frames
// Notes:   Released lines are resolved in the bench
module dlec_host (
  // Link drive
  output logic       sclk,
  output logic       cs_n,
  output logic [1:0] hd,
  output logic       hoe,
  // Link sense
  input wire [1:0]   dq
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle link at start
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    hd = 2'b00;
    hoe = 1'b0;
  end
  // Drive a pair while low, sample late while high
  task automatic tick(input logic [1:0] p, input logic rx, output logic [1:0] q);
    hd = p;
    hoe = !rx;
    #80 sclk = 1'b1;
    #70 q = dq;
    #10 sclk = 1'b0;
  endtask
  // Byte as four pairs, high pair first
  task automatic put(input logic [7:0] b);
    logic [1:0] q;
    for (int i = 3; i >= 0; i--) tick(b[2*i+:2], 1'b0, q);
  endtask
  // Opcode, address, data low byte first, then read bytes
  task automatic frame(input logic [7:0] op, input int na, input logic [31:0] ad, input int nw,
                       input logic [15:0] wd, input int nr, input int gap, output logic [15:0] rd);
    logic [1:0] q;
    rd = 16'h0;
    cs_n = 1'b0;
    #40 put(op);
    for (int k = na - 1; k >= 0; k--) put(ad[8*k+:8]);
    for (int k = 0; k < nw; k++) put(wd[8*k+:8]);
    for (int k = 0; k < 4 * nr; k++) begin
      tick(2'b00, 1'b1, q);
      rd[8*(k/4)+6-2*(k%4)+:2] = q;
    end
    hoe = 1'b0;
    #40 cs_n = 1'b1;
    #(100 + gap);
  endtask
endmodule // dlec_host

// file: sim/dlec_monitor.sv
// Purpose: Port checks for the two-line command block
// Assumes: Bound to dlec_top, one clock domain
// Notes:   Bus answer timing, pin enables, reset state
module dlec_monitor (
  // Clock and reset
  input wire        core_clk,
  input wire        rst_n,
  // Link side
  input wire        link_cs_n,
  input wire        data_line_0_oe,
  input wire        data_line_1_oe,
  // Bus side
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 1ns;
  wire take = hsel && htrans[1] && hready;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Bus request, then exactly one wait cycle
  sequence s_take; take; endsequence
  sequence s_ans; !hreadyout ##1 hreadyout; endsequence
  property p_ans; s_take |=> s_ans; endproperty
  a_ans: assert property (p_ans) else $error("bus answer timing");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus error response");
  property p_hold; $changed(hrdata) |-> $past(take, 2) && hreadyout; endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_lone; $fell(hreadyout) |-> $past(take); endproperty
  a_lone: assert property (p_lone) else $error("wait without request");
  // Link pin enables
  property p_pair; data_line_0_oe == data_line_1_oe; endproperty
  a_pair: assert property (p_pair) else $error("enables differ");
  property p_quiet; link_cs_n [*8] |-> !data_line_0_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("driving while deselected");
  property p_sel; $rose(data_line_0_oe) |-> !link_cs_n; endproperty
  a_sel: assert property (p_sel) else $error("drive began unselected");
  property p_rst; disable iff (1'b0) !rst_n |=> hreadyout && !data_line_0_oe && hrdata == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule // dlec_monitor

// file: sim/tb_dual_line_erase_and_register_commands.sv
// Purpose: Self-checking bench for the two-line command block
// Assumes: Host model on the link, bus master tasks on AHB-Lite
// Notes:   Short persistent write time; expected state kept in plain variables
`include "dlec_map.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; $display("BAD %0t %h %h", $time, a, b); end end

module tb_dual_line_erase_and_register_commands;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire         hready;
  wire         hresp;
  wire [31:0]  hrdata;
  wire         sclk;
  wire         cs_n;
  wire         h_oe;
  wire [1:0]   h_d;
  wire [1:0]   d_out;
  wire [1:0]   d_oe;
  wire [1:0]   dq = (d_oe & d_out) | (~d_oe & (h_oe ? h_d : ~h_d));
  int          failures = 0;
  int          num_checks = 0;
  logic [31:0] seed = 32'h132d;
  logic [31:0] ar;
  logic [31:0] v;
  logic [31:0] a;
  logic [15:0] lr;
  logic [5:0]  m_sr = `DLEC_RST_SR;
  logic        m_latch = 1'b0;
  logic [7:0]  m_vc = `DLEC_RST_VC;
  logic [7:0]  m_ec = `DLEC_RST_EC;
  logic [15:0] m_nv = `DLEC_RST_NV;
  logic [6:0]  m_fl = 7'h00;
  logic [7:0]  ops [3] = '{`DLEC_OP_VC_WR, `DLEC_OP_EC_WR, `DLEC_OP_NV_WR};

  dlec_top #(.NV_WR_CYC(10)) u_dlec_top (
    .core_clk(core_clk), .rst_n(rst_n), .link_sclk(sclk), .link_cs_n(cs_n),
    .data_line_0_in(dq[0]), .data_line_1_in(dq[1]), .data_line_0_out(d_out[0]), .data_line_1_out(d_out[1]),
    .data_line_0_oe(d_oe[0]), .data_line_1_oe(d_oe[1]), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata));
  dlec_host u_dlec_host (.sclk(sclk), .cs_n(cs_n), .hd(h_d), .hoe(h_oe), .dq(dq));

  // Clock and watchdog
  always #10 core_clk = ~core_clk;
  initial begin
    #1ms;
    failures++;
    tally_and_finish();
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Wait for ready at a falling edge, keep the read data seen there, then step to the rising edge
  task automatic wt;
    @(negedge core_clk);
    while (hready !== 1'b1)
      @(negedge core_clk);
    ar = hrdata;
    @(posedge core_clk);
  endtask
  task automatic ahb(input logic w, input logic [5:0] ofs, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, ofs, 2'b00};
    hwrite <= w;
    wt();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    wt();
  endtask
  task automatic lk(input logic [7:0] op, input int n, input logic [31:0] ad, input int nw,
                    input logic [15:0] d, input int nr);
    u_dlec_host.frame(op, n, ad, nw, d, nr, rnd() % 200, lr);
  endtask
  // Unlock, then the gated command
  task automatic wr(input logic [7:0] op, input int n, input logic [31:0] ad, input int nw, input logic [15:0] d);
    lk(`DLEC_OP_WRITE_UNLOCK_CMD, 0, 0, 0, 0, 0);
    lk(op, n, ad, nw, d, 0);
  endtask
  // Poll busy until clear; a hang is left to the watchdog
  task automatic idle;
    do begin
      ahb(1'b0, `DLEC_OFS_STAT, 32'h0);
    end while (ar[0] !== 1'b0);
  endtask
  // Every link register but the locks, and the bus status and config words, against the model
  task automatic chk;
    lk(`DLEC_OP_SR_RD, 0, 0, 0, 0, 1);
    `CHK(lr[7:0], {m_sr, m_latch, 1'b0})
    lk(`DLEC_OP_FL_RD, 0, 0, 0, 0, 1);
    `CHK(lr[7:0], {1'b1, m_fl})
    lk(`DLEC_OP_VC_RD, 0, 0, 0, 0, 1);
    `CHK(lr[7:0], m_vc)
    lk(`DLEC_OP_EC_RD, 0, 0, 0, 0, 1);
    `CHK(lr[7:0], m_ec)
    lk(`DLEC_OP_NV_RD, 0, 0, 0, 0, 2);
    `CHK(lr, m_nv)
    ahb(1'b0, `DLEC_OFS_STAT, 32'h0);
    `CHK(ar, {m_ec, m_vc, 1'b1, m_fl, m_sr, m_latch, 1'b0})
    ahb(1'b0, `DLEC_OFS_NVCFG, 32'h0);
    `CHK(ar[15:0], m_nv)
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk();
    ahb(1'b0, 6'h20, 32'h0);
    `CHK(ar, 32'h0)
    v = rnd();
    lk(`DLEC_OP_VC_WR, 0, 0, 1, v[15:0], 0);
    lk(`DLEC_OP_VC_RD, 0, 0, 0, 0, 1);
    `CHK(lr[7:0], m_vc)
    for (int i = 0; i < 3; i++) begin
      v = rnd();
      lk(`DLEC_OP_WRITE_UNLOCK_CMD, 0, 0, 0, 0, 0);
      lk(`DLEC_OP_SR_RD, 0, 0, 0, 0, 1);
      `CHK(lr[1], 1'b1)
      lk(ops[i], 0, 0, i == 2 ? 2 : 1, v[15:0], 0);
      case (i)
        0: m_vc = v[7:0];
        1: m_ec = v[7:0];
        default: m_nv = v[15:0];
      endcase
      idle();
    end
    chk();
    // Sector erase paused, held, resumed
    a = {20'h0, 4'h2, v[7:0]};
    wr(`DLEC_OP_SECT, 3, a, 0, 0);
    lk(`DLEC_OP_PAUSE, 0, 0, 0, 0, 0);
    for (int i = 0; i < 2; i++) begin
      ahb(1'b0, `DLEC_OFS_STAT, 32'h0);
      `CHK({ar[14], ar[0]}, 2'b10)
      repeat (300) @(posedge core_clk);
    end
    lk(`DLEC_OP_RESUME, 0, 0, 0, 0, 0);
    idle();
    ahb(1'b1, `DLEC_OFS_MADDR, a);
    ahb(1'b0, `DLEC_OFS_MDATA, 32'h0);
    `CHK(ar[7:0], 8'hff)
    // Bulk erase runs on through a pause
    wr(`DLEC_OP_BULK, 0, 0, 0, 0);
    lk(`DLEC_OP_PAUSE, 0, 0, 0, 0, 0);
    ahb(1'b0, `DLEC_OFS_STAT, 32'h0);
    `CHK({ar[14], ar[0]}, 2'b01)
    idle();
    ahb(1'b1, `DLEC_OFS_MADDR, {20'h0, 4'h9, v[15:8]});
    ahb(1'b0, `DLEC_OFS_MDATA, 32'h0);
    `CHK(ar[7:0], 8'hff)
    // Four-byte address, sector lock, refused erase, flag clear
    ahb(1'b1, `DLEC_OFS_CTRL, 32'h1);
    m_fl[0] = 1'b1;
    a = {16'h0, 8'h07, v[23:16]};
    wr(`DLEC_OP_LK_WR, 4, a, 1, 16'h1);
    lk(`DLEC_OP_LK_RD, 4, a, 0, 0, 1);
    `CHK(lr[1:0], 2'b01)
    for (int i = 0; i < 2; i++) begin
      wr(`DLEC_OP_SECT, 4, a, 0, 0);
      lk(i ? `DLEC_OP_WRITE_UNLOCK_CMD : `DLEC_OP_WRDI, 0, 0, 0, 0, 0);
      m_latch = i[0];
      lk(`DLEC_OP_FL_RD, 0, 0, 0, 0, 1);
      `CHK(lr[7:0], {1'b1, m_fl | 7'h22})
      lk(`DLEC_OP_FL_CLR, 0, 0, 0, 0, 0);
      chk();
    end
    // Status store last, bit 7 kept clear; its bits are only read back
    v = rnd() & 32'h7c;
    wr(`DLEC_OP_SR_WR, 0, 0, 1, v[15:0]);
    m_sr = v[7:2];
    m_latch = 1'b0;
    idle();
    chk();
    tally_and_finish();
  end
endmodule // tb_dual_line_erase_and_register_commands

bind dlec_top dlec_monitor u_dlec_monitor (
  .core_clk(core_clk), .rst_n(rst_n), .link_cs_n(link_cs_n), .data_line_0_oe(data_line_0_oe),
  .data_line_1_oe(data_line_1_oe), .hsel(hsel), .htrans(htrans), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
